// file: rtl/cama_pkg.sv
// Shared constants and carrier types for the counter array block
package cama_pkg;

  // Register byte addresses
  localparam logic [7:0] CAMA_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CAMA_ADDR_COUNTER_MODE_REGISTER = 8'h04;
  localparam logic [7:0] CAMA_ADDR_COUNT = 8'h08;
  localparam logic [7:0] CAMA_BASE_MODE = 8'h10;
  localparam logic [7:0] CAMA_BASE_LOW = 8'h30;
  localparam logic [7:0] CAMA_BASE_HIGH = 8'h50;
  localparam logic [7:0] CAMA_BANK_MASK = 8'hF0;
  localparam int CAMA_MAX_MODULES = 5;

  // Array control register fields
  localparam int CAMA_CTRL_WRAP_BIT = 7;
  localparam int CAMA_CTRL_RUN_BIT = 6;
  localparam int CAMA_CTRL_FLAG_LSB = 0;

  // Counter mode register fields
  localparam int CAMA_COUNTER_MODE_REGISTER_IDLE_BIT = 7;
  localparam int CAMA_COUNTER_MODE_REGISTER_SRC_LSB = 1;
  localparam int CAMA_COUNTER_MODE_REGISTER_IE_BIT = 0;

  // Count source prescale divisors
  localparam logic [3:0] CAMA_DIV_SLOW_X2 = 4'h6;
  localparam logic [3:0] CAMA_DIV_SLOW = 4'hC;
  localparam logic [3:0] CAMA_DIV_FAST_X2 = 4'h2;
  localparam logic [3:0] CAMA_DIV_FAST = 4'h4;

  // Reset values
  localparam logic [15:0] CAMA_COUNT_RESET = 16'h0000;
  localparam logic [15:0] CAMA_VALUE_RESET = 16'h0000;
  localparam logic [15:0] CAMA_COUNT_TOP = 16'hFFFF;

  // Count source selection
  typedef enum logic [1:0] {
    CAMA_SRC_SLOW = 2'h0,
    CAMA_SRC_FAST = 2'h1,
    CAMA_SRC_TIMER = 2'h2,
    CAMA_SRC_PIN = 2'h3
  } cama_src_t;

  // Per-module mode register, bit 6 down to bit 0
  typedef struct packed {
    logic comparator_enable;
    logic rising_edge_capture;
    logic falling_edge_capture;
    logic flag_on_equal;
    logic flip_output_on_hit;
    logic pwm_enable;
    logic module_interrupt_enable;
  } cama_mode_t;

  // Counter mode register
  typedef struct packed {
    logic idle_halt_enable;
    cama_src_t count_source_sel;
    logic wrap_interrupt_enable;
  } cama_counter_mode_register_t;

  // Counter view handed to each module
  typedef struct packed {
    logic [15:0] count;
    logic advanced;
  } cama_time_t;

endpackage

// file: rtl/cama_tick.sv
// Count source prescaler and selector for the shared counter
`timescale 1ns/1ps
`default_nettype none
module cama_tick (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Selection
  input wire cama_pkg::cama_src_t src,
  input wire logic x2_mode,
  // Count sources
  input wire logic timer0_overflow,
  input wire logic external_count_pin,
  // Result
  output logic tick
);
  import cama_pkg::*;

  // Prescaler count and previous pin level
  typedef struct packed {
    logic [3:0] div;
    logic pin_prev;
  } cama_tick_state_t;

  cama_tick_state_t st;
  cama_tick_state_t next_st;
  logic [3:0] divisor;
  logic div_done;

  // Divisor depends on the source and the clock mode
  always_comb begin
    if (src == CAMA_SRC_SLOW) begin
      divisor = x2_mode ? CAMA_DIV_SLOW_X2 : CAMA_DIV_SLOW;
    end else begin
      divisor = x2_mode ? CAMA_DIV_FAST_X2 : CAMA_DIV_FAST;
    end
  end

  // Prescaler wraps at divisor, pin counts on falling edges
  always_comb begin
    next_st = st;
    tick = 1'b0;
    div_done = (st.div >= divisor - 4'h1);
    next_st.div = div_done ? 4'h0 : st.div + 4'h1;
    next_st.pin_prev = external_count_pin;
    unique case (src)
      CAMA_SRC_SLOW, CAMA_SRC_FAST: tick = div_done; // [R16]
      CAMA_SRC_TIMER: tick = timer0_overflow; // [R16]
      CAMA_SRC_PIN: tick = st.pin_prev & ~external_count_pin; // [R16]
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// file: rtl/cama_chan.sv
// One capture/compare module: edge capture, match, toggle and PWM output
`timescale 1ns/1ps
`default_nettype none
module cama_chan (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Setup and time base
  input wire cama_pkg::cama_mode_t mode,
  input wire logic [15:0] value,
  input wire cama_pkg::cama_time_t tb,
  // Pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // Events
  output logic capture,
  output logic event_hit
);
  import cama_pkg::*;

  // Previous input level and output latch
  typedef struct packed {
    logic pin_prev;
    logic out;
  } cama_chan_state_t;

  cama_chan_state_t st;
  cama_chan_state_t next_st;
  logic hit;

  // Capture, match and output update
  always_comb begin
    next_st = st;
    next_st.pin_prev = pin_in;
    capture = (mode.rising_edge_capture & pin_in & ~st.pin_prev) // [R10] [R11]
      | (mode.falling_edge_capture & ~pin_in & st.pin_prev); // [R10] [R11]
    hit = mode.comparator_enable & tb.advanced & (tb.count == value); // [R12] [R14]
    event_hit = capture | (hit & mode.flag_on_equal); // [R3] [R9]
    if (mode.pwm_enable & mode.comparator_enable) begin
      // Low below the compare low byte, high otherwise
      next_st.out = (tb.count[7:0] >= value[7:0]); // [R7] [R15] [R20]
    end else if (hit & mode.flip_output_on_hit) begin
      next_st.out = ~st.out; // [R8]
    end
  end

  assign pin_out = st.out;
  assign pin_oe = mode.comparator_enable;

  // State register, output idles high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{pin_prev: 1'b1, out: 1'b1};
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// file: rtl/cama_ctrl.sv
// Shared counter, flags, registers and AHB-Lite slave of the counter array
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Overflow sets wrap flag; interrupt if enabled
// R2: Only software clears the wrap flag
// R3: Control bits 0-4 are module event flags
// R4: Module flags stay set until software clears
// R5: Each module owns a mode register
// R6: Mode bit 0 enables module interrupt
// R7: Mode bit 1 selects PWM mode
// R8: Mode bit 2 toggles pin on match
// R9: Mode bit 3 sets flag on match
// R10: Bit 4 falling, bit 5 rising capture
// R11: Both edge bits capture every transition
// R12: Mode bit 6 enables the comparator
// R13: Capture loads counter into value registers
// R14: Value registers hold the compare point
// R15: Value registers set PWM duty cycle
// R16: Source bits pick counter clock source
// R17: Control bit 6 runs or stops counter
// R18: Mode bit halts counter in idle
// R19: Hardware set beats software clear
// R20: PWM low while count low below value
module cama_ctrl #(
  parameter int N_MOD = 5
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Processor state and count sources
  input wire logic idle_mode,
  input wire logic x2_mode,
  input wire logic timer0_overflow,
  input wire logic external_count_pin,
  // Module pins
  input wire logic [N_MOD-1:0] module_io_pin_in,
  output logic [N_MOD-1:0] module_io_pin_out,
  output logic [N_MOD-1:0] module_io_pin_oe,
  // Interrupt request
  output logic irq
);
  import cama_pkg::*;

  // Register map, one word each, data in the low bits:
  //   0x00 control: 7 wrap flag, 6 run, 4..0 module flags
  //   0x04 counter mode: 7 idle halt, 2..1 source, 0 wrap enable
  //   0x08 shared counter, 15..0
  //   0x10 + 4n mode of module n, 6..0
  //   0x30 + 4n value low byte of module n
  //   0x50 + 4n value high byte of module n
  // Sources: 0 slow and 1 fast prescale, 2 timer 0 overflow,
  // 3 falling edge of the external count pin.
  // Mode bits: 0 interrupt, 1 PWM, 2 toggle, 3 flag on match,
  // 4 falling and 5 rising capture, 6 comparator.
  // Unmapped words read zero and drop writes.
  // No wait states, always OKAY. Read data is picked at
  // the address edge and stands until the next read.
  // Writes land at the end of the data phase, so a read
  // overlapping a write to the same word sees old data.

  // Refuse module counts that the flag field cannot hold
  // The flag field holds five modules at most, and the decode
  // has four slots per bank nibble plus one slot above it.
  if (N_MOD < 1 || N_MOD > CAMA_MAX_MODULES) begin : g_bad_count
    $error("N_MOD must be 1 to 5");
  end

  // All registers live in one packed struct: one combinational
  // process builds the next copy, one clocked process stores it.
  // Reset clears it all: counter stopped, modes off, no flags.
  // Only the prescaler and module instances hold state besides it.
  // Whole block state
  typedef struct packed {
    logic [15:0] count;
    logic advanced;
    logic counter_run;
    logic counter_wrap_flag;
    logic [N_MOD-1:0] module_event_flag;
    cama_counter_mode_register_t counter_mode_register;
    logic [N_MOD-1:0][$bits(cama_mode_t)-1:0] modes;
    logic [N_MOD-1:0][15:0] values;
    logic [31:0] rd_data;
    logic dph_write;
    logic [7:0] dph_addr;
  } cama_state_t;

  cama_state_t st;
  cama_state_t next_st;

  // Links to the prescaler and modules
  // tick: one-cycle count strobe of the selected source
  // capture, event_hit: per-module one-cycle strobes
  // tb: counter view shared by every module
  // addr_take: a transfer is accepted at this edge
  // rd_word: read data for the address now on the bus
  logic tick;
  logic [N_MOD-1:0] capture;
  logic [N_MOD-1:0] event_hit;
  cama_time_t tb;
  logic addr_take;
  logic [31:0] rd_word;

  // Decode is shared by the read and write paths, so both agree
  // on the module a word belongs to. All ones marks an address
  // outside the bank or beyond N_MOD.
  // Module number addressed inside a bank, or all ones if outside
  function automatic logic [2:0] bank_index(input logic [7:0] addr, input logic [7:0] base);
    logic [2:0] idx;
    idx = 3'h7;
    if ((addr & CAMA_BANK_MASK) == base && addr[1:0] == 2'h0 && addr[3:2] < N_MOD) begin
      idx = {1'b0, addr[3:2]};
    end
    return idx;
  endfunction

  // Module number held in the top nibble for module 4 of each bank
  // Module 4 sits at the bank base plus 0x10, past the nibble.
  function automatic logic [2:0] module_of(input logic [7:0] addr, input logic [7:0] base);
    logic [2:0] idx;
    idx = bank_index(addr, base);
    if (addr == base + 8'h10 && N_MOD > 4) begin
      idx = 3'h4;
    end
    return idx;
  endfunction

  // The prescaler runs free whatever the run bit says, so a
  // stopped counter restarts at any prescaler phase; over whole
  // prescale periods the count is exact. x2_mode picks the
  // shorter divisors.
  // Count source prescaler
  cama_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .src(st.counter_mode_register.count_source_sel),
    .x2_mode(x2_mode),
    .timer0_overflow(timer0_overflow),
    .external_count_pin(external_count_pin),
    .tick(tick)
  );

  // Registered counter view: modules see what a bus read of the
  // counter would return in the same cycle.
  assign tb = '{count: st.count, advanced: st.advanced};

  // A match is only taken on the cycle after the counter moved,
  // so a counter standing on the compare value matches once,
  // and a software write of the counter never matches.
  // Match and toggle follow the shared counter only.
  // A module drives its pin while its comparator is on; the pin
  // input then reads back the driven level, so capture modes
  // make no sense together with the comparator.
  // One capture/compare unit per module
  for (genvar m = 0; m < N_MOD; m++) begin : g_mod
    cama_chan u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .mode(cama_mode_t'(st.modes[m])), // [R5]
      .value(st.values[m]),
      .tb(tb),
      .pin_in(module_io_pin_in[m]),
      .pin_out(module_io_pin_out[m]),
      .pin_oe(module_io_pin_oe[m]),
      .capture(capture[m]),
      .event_hit(event_hit[m])
    );
  end

  // Zero-wait slave, always OKAY
  // hready gates only the address phase; hsize is not checked,
  // every access is taken as a whole word.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rd_data;
  assign addr_take = hsel & hready & htrans[1];

  // The read word is built from the address phase and stored at
  // that edge, which lets the slave answer with no wait state.
  // Bits a register does not define read as zero.
  // Read multiplexer on the address phase
  always_comb begin
    logic [7:0] a;
    logic [2:0] mi;
    mi = 3'h7;
    a = haddr[7:0];
    rd_word = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      if (a == CAMA_ADDR_CTRL) begin
        rd_word[CAMA_CTRL_WRAP_BIT] = st.counter_wrap_flag;
        rd_word[CAMA_CTRL_RUN_BIT] = st.counter_run;
        rd_word[CAMA_CTRL_FLAG_LSB +: N_MOD] = st.module_event_flag;
      end else if (a == CAMA_ADDR_COUNTER_MODE_REGISTER) begin
        rd_word[CAMA_COUNTER_MODE_REGISTER_IDLE_BIT] = st.counter_mode_register.idle_halt_enable;
        rd_word[CAMA_COUNTER_MODE_REGISTER_SRC_LSB +: 2] = st.counter_mode_register.count_source_sel;
        rd_word[CAMA_COUNTER_MODE_REGISTER_IE_BIT] = st.counter_mode_register.wrap_interrupt_enable;
      end else if (a == CAMA_ADDR_COUNT) begin
        rd_word[15:0] = st.count;
      end else begin
        mi = module_of(a, CAMA_BASE_MODE);
        if (mi != 3'h7) begin
          rd_word[$bits(cama_mode_t)-1:0] = st.modes[mi];
        end
        mi = module_of(a, CAMA_BASE_LOW);
        if (mi != 3'h7) begin
          rd_word[7:0] = st.values[mi][7:0];
        end
        mi = module_of(a, CAMA_BASE_HIGH);
        if (mi != 3'h7) begin
          rd_word[7:0] = st.values[mi][15:8];
        end
      end
    end
  end

  // Next-state logic: bus writes, counter, flags and captures
  // Order inside: bus phases, writes, counter, captures, flags,
  // so later hardware steps override earlier software ones.
  always_comb begin
    logic [2:0] mi;
    logic sw_ctrl;
    logic halted;
    next_st = st;
    mi = 3'h7;
    sw_ctrl = st.dph_write && st.dph_addr == CAMA_ADDR_CTRL;

    // Address phase capture and read data
    // Only selected NONSEQ or SEQ transfers with the bus ready
    // start a data phase; an address outside the block keeps an
    // unmapped offset so that its write lands nowhere.
    if (addr_take) begin
      next_st.dph_write = hwrite;
      next_st.dph_addr = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
      if (!hwrite) begin
        next_st.rd_data = rd_word;
      end
    end else if (hready) begin
      next_st.dph_write = 1'b0;
    end

    // Data phase writes
    // Writes use the address taken in the previous cycle and the
    // data standing now; hardware events below are applied after
    // them, so an event in the same cycle wins over software.
    if (st.dph_write) begin
      if (sw_ctrl) begin
        // Run and flags take the written bits: zero clears a flag,
        // one sets it by software.
        next_st.counter_run = hwdata[CAMA_CTRL_RUN_BIT]; // [R17]
        next_st.counter_wrap_flag = hwdata[CAMA_CTRL_WRAP_BIT]; // [R2]
        next_st.module_event_flag = hwdata[CAMA_CTRL_FLAG_LSB +: N_MOD]; // [R4]
      end else if (st.dph_addr == CAMA_ADDR_COUNTER_MODE_REGISTER) begin
        // Source and enables act from the next cycle
        next_st.counter_mode_register.idle_halt_enable = hwdata[CAMA_COUNTER_MODE_REGISTER_IDLE_BIT];
        next_st.counter_mode_register.count_source_sel = cama_src_t'(hwdata[CAMA_COUNTER_MODE_REGISTER_SRC_LSB +: 2]);
        next_st.counter_mode_register.wrap_interrupt_enable = hwdata[CAMA_COUNTER_MODE_REGISTER_IE_BIT];
      end else if (st.dph_addr == CAMA_ADDR_COUNT) begin
        next_st.count = hwdata[15:0];
      end else begin
        mi = module_of(st.dph_addr, CAMA_BASE_MODE);
        if (mi != 3'h7) begin
          next_st.modes[mi] = hwdata[$bits(cama_mode_t)-1:0]; // [R5]
        end
        mi = module_of(st.dph_addr, CAMA_BASE_LOW);
        if (mi != 3'h7) begin
          next_st.values[mi][7:0] = hwdata[7:0]; // [R14]
        end
        mi = module_of(st.dph_addr, CAMA_BASE_HIGH);
        if (mi != 3'h7) begin
          next_st.values[mi][15:8] = hwdata[7:0]; // [R14]
        end
      end
    end

    // Shared counter advances on its source while running
    // The wrap flag sets on the tick that carries the counter from
    // all ones to zero. A counter write in the same cycle as a
    // tick loses to the tick; stop the counter first if the
    // written value must stick.
    // Idle halt stops only the counter, only while the processor
    // is idle; the prescaler keeps running meanwhile.
    halted = idle_mode & st.counter_mode_register.idle_halt_enable; // [R18]
    next_st.advanced = 1'b0;
    if (st.counter_run && !halted && tick) begin // [R17]
      next_st.count = st.count + 16'h0001;
      next_st.advanced = 1'b1;
      if (st.count == CAMA_COUNT_TOP) begin
        next_st.counter_wrap_flag = 1'b1; // [R1] [R19]
      end
    end

    // Captures win over software writes to the value registers
    // A capture copies the count as it stood before this edge's
    // increment, the count at which the pin moved.
    for (int m = 0; m < N_MOD; m++) begin
      if (capture[m]) begin
        next_st.values[m] = st.count; // [R13]
      end
    end

    // Hardware set overrides any software clear this cycle
    // Events are ORed in after the write, so a clear in the cycle
    // of a capture or match leaves the flag set.
    next_st.module_event_flag = next_st.module_event_flag | event_hit; // [R3] [R19]
  end

  // Plain level: high while any enabled flag is set, falls only
  // when software clears a flag or its enable.
  // Interrupt request from enabled flags
  always_comb begin
    logic mod_req;
    cama_mode_t md;
    mod_req = 1'b0;
    md = '0;
    for (int m = 0; m < N_MOD; m++) begin
      md = cama_mode_t'(st.modes[m]);
      mod_req = mod_req | (st.module_event_flag[m] & md.module_interrupt_enable); // [R6]
    end
    irq = mod_req | (st.counter_wrap_flag & st.counter_mode_register.wrap_interrupt_enable); // [R1]
  end

  // Reset is asynchronous and loads constants only;
  // everything else moves on the rising clock edge.
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// file: verification/cama_pins.sv
// External pin model: capture inputs, count sources and shared pins
`timescale 1ns/1ps
`default_nettype none
module cama_pins (
  // Clock
  input wire logic hclk,
  // Design pins
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  output logic [4:0] pin_in,
  // Count sources
  output logic tmr,
  output logic ext
);
  // Levels this side drives on the capture inputs
  logic [4:0] drv = 5'h00;
  initial tmr = 1'b0;
  initial ext = 1'b1;
  // Shared pin level: the block wins where it drives
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  // Move one capture input, then let it settle
  task automatic set_in(input int i, input logic v);
    @(posedge hclk) drv[i] <= v;
    repeat (3) @(posedge hclk);
  endtask
  // One-cycle timer overflow pulses
  task automatic tmr_pulse(input int k);
    repeat (k) begin
      @(posedge hclk) tmr <= 1'b1;
      @(posedge hclk) tmr <= 1'b0;
    end
    repeat (3) @(posedge hclk);
  endtask
  // Falling edges on the external count input
  task automatic ext_fall(input int k);
    repeat (k) begin
      @(posedge hclk) ext <= 1'b0;
      @(posedge hclk) ext <= 1'b1;
    end
    repeat (3) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// file: verification/cama_ctrl_sva.sv
// Port checker for the counter array block
`timescale 1ns/1ps
`default_nettype none
module cama_ctrl_sva #(
  parameter int N_MOD = 5
) (
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Pins and interrupt
  input wire logic [N_MOD-1:0] module_io_pin_out,
  input wire logic [N_MOD-1:0] module_io_pin_oe,
  input wire logic irq
);
  import cama_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Transfer accepted at this edge
  logic act;
  assign act = hsel && hready && htrans[1];
  sequence s_wr(logic [7:0] a);
    act && hwrite && haddr == {24'h0, a};
  endsequence
  sequence s_rd(logic [7:0] a);
    act && !hwrite && haddr == {24'h0, a};
  endsequence
  // Write, idle data phase, then read of the same place
  property p_back(logic [7:0] a);
    s_wr(a) ##1 !act ##1 s_rd(a) |=> hrdata[7:0] == {1'b0, $past(hwdata[6:0], 2)};
  endproperty
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_reset_pins: assert property ($rose(hresetn) |->
    module_io_pin_out == '1 && module_io_pin_oe == '0 && !irq)
    else $error("pins or irq wrong after reset");
  a_unmapped_zero: assert property (s_rd(8'h0C) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (act && !hwrite |=> hrdata[31:16] == 16'h0000)
    else $error("read upper bits not zero");
  a_mode_back: assert property (p_back(CAMA_BASE_MODE))
    else $error("mode register read back wrong");
  a_oe_follows: assert property (s_wr(CAMA_BASE_MODE) |=> ##1
    module_io_pin_oe[0] == $past(hwdata[6]))
    else $error("pin enable does not follow comparator bit");
  a_pin_quiet: assert property (((~module_io_pin_oe & ~$past(module_io_pin_oe))
    & (module_io_pin_out ^ $past(module_io_pin_out))) == '0)
    else $error("pin moved with comparator off");
  a_irq_sw_only: assert property ($fell(irq) |-> $past(act && hwrite, 2))
    else $error("irq fell without a write");
endmodule
bind cama_ctrl cama_ctrl_sva #(.N_MOD(N_MOD)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .module_io_pin_out(module_io_pin_out), .module_io_pin_oe(module_io_pin_oe),
  .irq(irq)
);
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the counter array block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cama_pkg::*;
  // Bus and control drives
  logic hclk, hresetn, hsel, hwrite, idle_mode, x2_mode;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  // Block outputs and pin wires
  wire logic hreadyout, hresp, irq, tmr, ext;
  wire logic [31:0] hrdata;
  wire logic [4:0] pin_in, pin_out, pin_oe;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] rdat;
  // Register rows: address, written word, expected read
  localparam logic [71:0] ROWS [11] = '{
    {8'h10, 32'hFFBF, 32'h3F}, {8'h14, 32'h15, 32'h15}, {8'h18, 32'h2A, 32'h2A},
    {8'h1C, 32'h01, 32'h01}, {8'h20, 32'h12, 32'h12}, {8'h30, 32'h12AB, 32'hAB},
    {8'h50, 32'hFFCD, 32'hCD}, {8'h08, 32'h1BEEF, 32'hBEEF}, {8'h04, 32'hFF87, 32'h87},
    {8'h0C, 32'hFFFF, 32'h0}, {8'h70, 32'hFFFF, 32'h0}};
  cama_ctrl #(.N_MOD(5)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .idle_mode(idle_mode),
    .x2_mode(x2_mode), .timer0_overflow(tmr), .external_count_pin(ext),
    .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
    .module_io_pin_oe(pin_oe), .irq(irq));
  cama_pins pins (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .tmr(tmr), .ext(ext));
  // Clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One single transfer, waiting on the slave's ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // Verdict and end of run
  task automatic print_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  initial begin
    #20000;
    bad_count++;
    print_verdict;
  end
  // Main sequence
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; idle_mode = 1'b0; x2_mode = 1'b0; hresetn = 1'b0; hsize = 3'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1 chk(32'({irq, pin_oe, pin_out}), 32'h01F);
    rd(8'h00, 32'h0);
    foreach (ROWS[i]) begin
      wr(ROWS[i][71:64], ROWS[i][63:32]);
      rd(ROWS[i][71:64], ROWS[i][31:0]);
    end
    // Edge capture on modules 0, 1 and 2
    wr(8'h08, 32'h0100);
    wr(8'h10, 32'h21);
    pins.set_in(0, 1'b1);
    rd(8'h00, 32'h01);
    #1 chk(32'(irq), 32'h1);
    rd(8'h30, 32'h00);
    rd(8'h50, 32'h01);
    wr(8'h08, 32'h0222);
    pins.set_in(0, 1'b0);
    rd(8'h30, 32'h00);
    wr(8'h14, 32'h30);
    pins.set_in(1, 1'b1);
    rd(8'h34, 32'h22);
    wr(8'h08, 32'h0333);
    pins.set_in(1, 1'b0);
    rd(8'h34, 32'h33);
    wr(8'h18, 32'h10);
    pins.set_in(2, 1'b1);
    rd(8'h38, 32'h00);
    wr(8'h08, 32'h0444);
    pins.set_in(2, 1'b0);
    rd(8'h38, 32'h44);
    rd(8'h00, 32'h07);
    wr(8'h00, 32'h0);
    #1 chk(32'(irq), 32'h0);
    // Wrap from timer overflow, stop and idle halt
    wr(8'h04, 32'h05);
    wr(8'h08, 32'hFFFE);
    wr(8'h00, 32'h40);
    pins.tmr_pulse(2);
    rd(8'h08, 32'h0);
    rd(8'h00, 32'hC0);
    #1 chk(32'(irq), 32'h1);
    rd(8'h00, 32'hC0);
    wr(8'h00, 32'h40);
    rd(8'h00, 32'h40);
    wr(8'h00, 32'h0);
    pins.tmr_pulse(3);
    rd(8'h08, 32'h0);
    wr(8'h04, 32'h84);
    wr(8'h00, 32'h40);
    idle_mode <= 1'b1;
    pins.tmr_pulse(2);
    rd(8'h08, 32'h0);
    idle_mode <= 1'b0;
    pins.tmr_pulse(2);
    rd(8'h08, 32'h2);
    wr(8'h04, 32'h06);
    wr(8'h08, 32'h0);
    pins.ext_fall(3);
    rd(8'h08, 32'h3);
    // Match with toggle on module 3
    wr(8'h3C, 32'h05);
    wr(8'h5C, 32'h00);
    wr(8'h08, 32'h04);
    wr(8'h1C, 32'h4C);
    #1 chk(32'(pin_oe[3]), 32'h1);
    pins.ext_fall(1);
    rd(8'h00, 32'h48);
    #1 chk(32'(pin_out[3]), 32'h0);
    // Duty cycle on module 4
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h80);
    wr(8'h08, 32'h10);
    wr(8'h20, 32'h42);
    repeat (2) @(posedge hclk);
    #1 chk(32'(pin_out[4]), 32'h0);
    wr(8'h08, 32'h0190);
    repeat (2) @(posedge hclk);
    #1 chk(32'(pin_out[4]), 32'h1);
    // Prescaled sources: count over a run window of 12 cycles
    for (int k = 0; k < 4; k++) begin
      x2_mode <= k[0];
      wr(8'h04, k[1] ? 32'h02 : 32'h00);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h40);
      repeat (10) @(posedge hclk);
      wr(8'h00, 32'h0);
      rd(8'h08, 32'h0C / (k[1] ? (k[0] ? CAMA_DIV_FAST_X2 : CAMA_DIV_FAST)
        : (k[0] ? CAMA_DIV_SLOW_X2 : CAMA_DIV_SLOW)));
    end
    print_verdict;
  end
endmodule
`default_nettype wire
